// ===== dma_cfg_regs.v
`timescale 1ns/10ps
`include "dma_defs.vh"
module dma_cfg_regs (
	input wire aclk,
	input wire aresetn,
	input wire clear,
	input wire [7:0] wr_addr,
	input wire [7:0] wr_data,
	input wire wr_en,
	output reg [7:0] ctrl1,
	output reg [21:0] source_start_addr,
	output reg [11:0] source_size,
	output reg [15:0] dest_start_addr,
	output reg [11:0] dsz
);
	// Writable setup registers
	always @(posedge aclk) begin
		if (!aresetn || clear) begin // [R17] [R21]
			ctrl1 <= `REG_RESET;
			source_start_addr <= 22'h000000;
			source_size <= 12'h000;
			dest_start_addr <= 16'h0000;
			dsz <= 12'h000;
		end else if (wr_en) begin
			case (wr_addr)
				`OFS_ADDR_CTRL: ctrl1 <= wr_data;
				`OFS_SSA_L: source_start_addr[7:0] <= wr_data; // [R12]
				`OFS_SSA_H: source_start_addr[15:8] <= wr_data;
				`OFS_SSA_U: source_start_addr[21:16] <= wr_data[5:0]; // [R18]
				`OFS_SSZ_L: source_size[7:0] <= wr_data; // [R14]
				`OFS_SSZ_H: source_size[11:8] <= wr_data[3:0];
				`OFS_DSA_L: dest_start_addr[7:0] <= wr_data; // [R16]
				`OFS_DSA_H: dest_start_addr[15:8] <= wr_data;
				`OFS_DSZ_L: dsz[7:0] <= wr_data;
				`OFS_DSZ_H: dsz[11:8] <= wr_data[3:0];
				default: ;
			endcase
		end
	end
endmodule

// ===== dma_channel.v
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "dma_defs.vh"
// Overview of operation
// [R1] Channel moves data only while enabled
// [R2] Start trigger enable gates hardware start
// [R3] Go flag shows transaction in progress
// [R4] Abort trigger enable gates hardware abort
// [R5] Pending flag marks undelivered staging byte
// [R6] Destination pointer hold, increment or decrement
// [R7] Destination reload may clear start enable
// [R8] Region select routes source reads
// [R9] Source pointer hold, increment or decrement
// [R10] Source reload may clear start enable
// [R11] Staging byte readable by software
// [R12] Source start address writable, 22 bits
// [R13] Source pointer readable, upper bits zero
// [R14] Source size writable, 12 bits
// [R15] Source remaining count readable, 12 bits
// [R16] Destination start address writable, 16 bits
// [R17] All fields clear on reset
// [R18] Unused bits read zero, ignore writes
// [R19] Abort finishes read, clears go, enables
// [R20] Go again resumes from stopped state
// [R21] Clearing enable resets channel registers
// [R22] Message completion reloads pointers and counters
module dma_channel (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire start_trigger,
	input wire abort_trigger,
	output reg mem_req,
	output reg mem_write,
	output reg [1:0] mem_region,
	output reg [21:0] mem_addr,
	output reg [7:0] mem_wdata,
	input wire mem_grant,
	input wire [7:0] mem_rdata
);
	localparam ST_IDLE = 2'd0;
	localparam ST_READ = 2'd1;
	localparam ST_WRITE = 2'd2;

	reg [1:0] state;
	reg enable;
	reg start_en;
	reg go;
	reg abort_en;
	reg pending;
	reg [7:0] stage;
	reg [21:0] source_pointer;
	reg [15:0] dest_pointer;
	reg [11:0] source_remaining;
	reg [11:0] dest_remaining;
	reg aw_held;
	reg w_held;
	reg [7:0] aw_q;
	reg [7:0] w_q;
	reg w_lane;
	reg abort_pend;
	wire [7:0] ctrl1;
	wire [21:0] source_start_addr;
	wire [11:0] source_size;
	wire [15:0] dest_start_addr;
	wire [11:0] dsz;
	wire [1:0] dest_addr_mode = ctrl1[`DEST_ADDR_MODE_HI:`DEST_ADDR_MODE_LO];
	wire [1:0] source_addr_mode = ctrl1[`SOURCE_ADDR_MODE_HI:`SOURCE_ADDR_MODE_LO];

	// Write channel capture, either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	wire aw_now = aw_held || s_axi_awvalid;
	wire w_now = w_held || s_axi_wvalid;
	wire [7:0] aw_addr = aw_held ? aw_q : s_axi_awaddr[7:0];
	wire [7:0] w_data = w_held ? w_q : s_axi_wdata[7:0];
	wire w_strb = w_held ? w_lane : s_axi_wstrb[0];
	wire wr_fire = aw_now && w_now && !s_axi_bvalid;
	reg aw_hi_bad;
	// Upper bits of a held address were judged when taken
	wire aw_hi_now = aw_held ? aw_hi_bad :
		(s_axi_awaddr[31:8] != 24'h000000);
	// Unmapped or misaligned writes change nothing, answer an error
	wire wr_bad = aw_hi_now || aw_addr > `OFS_DEST_REMAINING_H ||
		aw_addr[1:0] != 2'b00;
	wire wr_en = wr_fire && w_strb && !wr_bad;
	wire wr_main = wr_en && aw_addr == `OFS_CTRL_MAIN;
	wire wr_cfg = wr_en && enable && aw_addr != `OFS_CTRL_MAIN;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_q <= 8'h00;
			w_q <= 8'h00;
			w_lane <= 1'b0;
			aw_hi_bad <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_bad ? `RESP_SLVERR : `RESP_OKAY;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held <= 1'b1;
					aw_q <= s_axi_awaddr[7:0];
					aw_hi_bad <= s_axi_awaddr[31:8] != 24'h000000;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held <= 1'b1;
					w_q <= s_axi_wdata[7:0];
					w_lane <= s_axi_wstrb[0];
				end
			end
		end
	end

	// Setup registers are writable only while enabled
	dma_cfg_regs u_cfg (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(!enable),
		.wr_addr(aw_addr),
		.wr_data(w_data),
		.wr_en(wr_cfg),
		.ctrl1(ctrl1),
		.source_start_addr(source_start_addr),
		.source_size(source_size),
		.dest_start_addr(dest_start_addr),
		.dsz(dsz)
	);

	// Transfer engine
	wire run = enable && go; // [R1]
	wire hw_start = start_en && start_trigger && !go; // [R2]
	wire hw_abort = abort_en && abort_trigger && go; // [R4]
	wire s_last = source_remaining == 12'h001;
	wire d_last = dest_remaining == 12'h001;
	wire rd_done = state == ST_READ && mem_grant;
	wire wr_done = state == ST_WRITE && mem_grant;
	wire s_reload = rd_done && s_last;
	wire d_reload = wr_done && d_last;

	wire s_load = source_remaining == 12'h000 && !go;
	wire d_load = dest_remaining == 12'h000 && !go;
	wire [11:0] next_source_remaining = source_remaining - 12'h001;
	wire [11:0] next_dest_remaining = dest_remaining - 12'h001;
	// Region code, upper bit alone selects EEPROM
	wire [1:0] next_region = ctrl1[`SMR_HI] ? 2'b10 :
		ctrl1[`SMR_HI:`SMR_LO];
	// Main control view, unused bits read zero
	wire [7:0] ctrl0_view = {enable, start_en, go, 2'b00, abort_en, 1'b0,
		pending};
	// Disable, or a write clearing the enable, wipes the channel
	wire wipe = !aresetn || (wr_main && !w_data[`BIT_EN]) || !enable;

	function [21:0] step22;
		input [21:0] v;
		input [1:0] m;
		begin
			case (m)
				`MODE_INC: step22 = v + 22'h000001;
				`MODE_DEC: step22 = v - 22'h000001;
				default: step22 = v;
			endcase
		end
	endfunction

	// Pointer steps after each completed access, except the last of a count, which reloads
	reg [21:0] next_source_pointer;
	reg [21:0] dest_pointer_wide;
	reg [15:0] next_dest_pointer;
	always @* begin
		next_source_pointer = step22(source_pointer, source_addr_mode); // [R9]
		dest_pointer_wide = step22({6'h00, dest_pointer}, dest_addr_mode);
		next_dest_pointer = dest_pointer_wide[15:0]; // [R6]
	end

	// Main control and transfer state
	always @(posedge aclk) begin
		if (wipe) begin // [R17] [R21]
			enable <= (aresetn && wr_main) ? w_data[`BIT_EN] : 1'b0;
			start_en <= 1'b0;
			go <= 1'b0;
			abort_en <= 1'b0;
			pending <= 1'b0;
			abort_pend <= 1'b0;
			stage <= `REG_RESET;
			source_pointer <= 22'h000000;
			dest_pointer <= 16'h0000;
			source_remaining <= 12'h000;
			dest_remaining <= 12'h000;
			state <= ST_IDLE;
			mem_req <= 1'b0;
			mem_write <= 1'b0;
			mem_region <= 2'b00;
			mem_addr <= 22'h000000;
			mem_wdata <= 8'h00;
		end else begin
			if (wr_main) begin
				start_en <= w_data[`BIT_SIRQ];
				abort_en <= w_data[`BIT_AIRQ];
				go <= w_data[`BIT_GO]; // [R3] [R20]
			end
			// Reload pointers and counters while idle and the count is zero
			if (s_load) begin
				source_remaining <= source_size; // [R22]
				source_pointer <= source_start_addr;
			end
			if (d_load) begin
				dest_remaining <= dsz;
				dest_pointer <= dest_start_addr;
			end
			if (hw_start)
				go <= 1'b1; // [R2] [R3]
			// Abort waits for the access in flight
			if (hw_abort)
				abort_pend <= 1'b1;
			case (state)
				ST_IDLE: begin
					mem_req <= 1'b0;
					if (abort_pend || hw_abort) begin
						go <= 1'b0; // [R19]
						start_en <= 1'b0;
						abort_en <= 1'b0;
						abort_pend <= 1'b0;
					end else if (run && source_remaining != 12'h000) begin
						state <= pending ? ST_WRITE : ST_READ;
						mem_req <= 1'b1;
						mem_write <= pending;
						mem_region <= next_region; // [R8]
						mem_addr <= pending ? {6'h00, dest_pointer} : source_pointer;
						mem_wdata <= stage;
					end
				end
				ST_READ: if (mem_grant) begin
					stage <= mem_rdata; // [R11]
					pending <= 1'b1; // [R5]
					mem_req <= 1'b0;
					state <= ST_IDLE;
					if (s_reload) begin
						source_remaining <= source_size; // [R22]
						source_pointer <= source_start_addr;
						if (ctrl1[`BIT_SOURCE_RELOAD_STOP])
							start_en <= 1'b0; // [R10]
					end else begin
						source_remaining <= next_source_remaining;
						source_pointer <= next_source_pointer; // [R9]
					end
				end
				ST_WRITE: if (mem_grant) begin
					pending <= 1'b0; // [R5]
					mem_req <= 1'b0;
					state <= ST_IDLE;
					if (d_reload) begin
						dest_remaining <= dsz; // [R22]
						dest_pointer <= dest_start_addr;
						go <= 1'b0; // [R3]
						if (ctrl1[`BIT_DEST_RELOAD_STOP])
							start_en <= 1'b0; // [R7]
					end else begin
						dest_remaining <= next_dest_remaining;
						dest_pointer <= next_dest_pointer; // [R6]
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Read channel
	assign s_axi_arready = !s_axi_rvalid;
	reg [7:0] rd_val;
	reg rd_bad;
	always @* begin
		// Unmapped or misaligned reads answer an error
		rd_bad = s_axi_araddr[31:8] != 24'h000000 ||
			s_axi_araddr[1:0] != 2'b00;
		case (s_axi_araddr[7:0])
			`OFS_CTRL_MAIN: rd_val = ctrl0_view; // [R18]
			`OFS_ADDR_CTRL: rd_val = ctrl1;
			`OFS_STAGE: rd_val = stage; // [R11]
			`OFS_SSA_L: rd_val = source_start_addr[7:0];
			`OFS_SSA_H: rd_val = source_start_addr[15:8];
			`OFS_SSA_U: rd_val = {2'b00, source_start_addr[21:16]};
			`OFS_SOURCE_POINTER_L: rd_val = source_pointer[7:0]; // [R13]
			`OFS_SOURCE_POINTER_H: rd_val = source_pointer[15:8];
			`OFS_SOURCE_POINTER_U: rd_val = {2'b00, source_pointer[21:16]};
			`OFS_SSZ_L: rd_val = source_size[7:0];
			`OFS_SSZ_H: rd_val = {4'h0, source_size[11:8]};
			`OFS_SOURCE_REMAINING_L: rd_val = source_remaining[7:0]; // [R15]
			`OFS_SOURCE_REMAINING_H: rd_val = {4'h0, source_remaining[11:8]};
			`OFS_DSA_L: rd_val = dest_start_addr[7:0];
			`OFS_DSA_H: rd_val = dest_start_addr[15:8];
			`OFS_DEST_POINTER_L: rd_val = dest_pointer[7:0];
			`OFS_DEST_POINTER_H: rd_val = dest_pointer[15:8];
			`OFS_DSZ_L: rd_val = dsz[7:0];
			`OFS_DSZ_H: rd_val = {4'h0, dsz[11:8]};
			`OFS_DEST_REMAINING_L: rd_val = dest_remaining[7:0];
			`OFS_DEST_REMAINING_H: rd_val = {4'h0, dest_remaining[11:8]};
			default: begin
				rd_val = 8'h00;
				rd_bad = 1'b1;
			end
		endcase
	end

	// Reads answer one cycle after the address
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end else if (s_axi_arvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_val};
			s_axi_rresp <= rd_bad ? `RESP_SLVERR : `RESP_OKAY;
		end
	end
endmodule

// ===== dma_channel_checker.sv
`timescale 1ns/10ps
module dma_channel_checker (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire mem_req,
	input wire mem_write,
	input wire [21:0] mem_addr,
	input wire [7:0] mem_wdata,
	input wire mem_grant,
	input wire [7:0] mem_rdata
);
	reg [7:0] held;
	always @(posedge aclk) begin
		if (!aresetn)
			held <= 8'h00;
		else if (mem_req && !mem_write && mem_grant)
			held <= mem_rdata;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence rd_done;
		mem_req && !mem_write && mem_grant;
	endsequence
	sequence wr_on;
		mem_req && mem_write;
	endsequence
	chk_b_stands: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid");
	chk_r_stands: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("rvalid");
	chk_high_zero: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("rdata");
	chk_req_holds: assert property (
		mem_req && !mem_grant |=> mem_req && $stable(mem_addr)) else $error("req");
	chk_read_gap: assert property (rd_done |=> !mem_req)
		else $error("read gap");
	chk_write_gap: assert property (
		mem_req && mem_write && mem_grant |=> !mem_req) else $error("write gap");
	chk_dst_width: assert property (
		wr_on |-> mem_addr[21:16] == 6'h00) else $error("dest addr");
	chk_byte_moved: assert property (wr_on |-> mem_wdata == held)
		else $error("byte");
	chk_reset_quiet: assert property (disable iff (1'b0)
		!aresetn |=> !mem_req && !s_axi_bvalid && !s_axi_rvalid) else $error("rst");
endmodule
bind dma_channel dma_channel_checker u_chk(.aclk, .aresetn, .s_axi_bvalid,
	.s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .mem_req,
	.mem_write, .mem_addr, .mem_wdata, .mem_grant, .mem_rdata);

// ===== dma_channel_control_regs_tb_top.sv
`timescale 1ns/10ps
`include "dma_defs.vh"
module dma_channel_control_regs_tb_top;
	reg aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	reg s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	reg start_trigger = 1'b0, abort_trigger = 1'b0, slow = 1'b0;
	reg [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, mem_req, mem_write, mem_grant;
	wire [1:0] s_axi_bresp, s_axi_rresp, mem_region, rreg;
	wire [31:0] s_axi_rdata;
	wire [21:0] mem_addr, waddr, raddr;
	wire [7:0] mem_wdata, mem_rdata, wbyte;
	integer errors = 0, checks = 0, cyc = 0, nwr;
	reg [31:0] v;
	reg [1:0] r;
	dma_channel u_dut(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .start_trigger, .abort_trigger, .mem_req, .mem_write,
		.mem_region, .mem_addr, .mem_wdata, .mem_grant, .mem_rdata);
	mem_model u_mem(.aclk, .aresetn, .mem_req, .mem_write, .mem_region,
		.mem_addr, .mem_wdata, .slow, .mem_grant, .mem_rdata, .waddr, .wbyte,
		.raddr, .rreg, .nwr);
	initial begin
		forever #10 aclk = ~aclk;
	end
	task automatic chk(input [31:0] got, input [31:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input [7:0] a, input [7:0] d);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			ta = ta | s_axi_awready;
			tw = tw | s_axi_wready;
		end
		while (!s_axi_bvalid) @(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge aclk);
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rc(input [7:0] a, input [31:0] e);
		rd(a);
		chk(v, e);
	endtask
	task automatic wait_idle;
		v = 32'h20;
		for (int k = 0; k < 200 && v[5]; k++) rd(`OFS_CTRL_MAIN);
	endtask
	task automatic pulse;
		@(posedge aclk);
		start_trigger <= 1'b1;
		@(posedge aclk);
		start_trigger <= 1'b0;
		repeat (6) @(posedge aclk);
	endtask
	task automatic t_regs;
		for (int k = 0; k <= 8'h50; k += 4) rc(k[7:0], 32'h0);
		rd(8'h54);
		chk({30'h0, r}, {30'h0, `RESP_SLVERR});
		wr(`OFS_CTRL_MAIN, 8'h9b);
		chk({30'h0, r}, {30'h0, `RESP_OKAY});
		rc(`OFS_CTRL_MAIN, 32'h80);
		wr(8'h54, 8'hff);
		chk({30'h0, r}, {30'h0, `RESP_SLVERR});
		wr(`OFS_SSA_U, 8'hff);
		rc(`OFS_SSA_U, 32'h3f);
		wr(`OFS_SSZ_H, 8'hff);
		rc(`OFS_SSZ_H, 32'h0f);
		wr(`OFS_CTRL_MAIN, 8'h00);
		rc(`OFS_SSA_U, 32'h0);
	endtask
	task automatic t_move;
		logic [1:0] m;
		logic [21:0] st;
		wr(`OFS_CTRL_MAIN, 8'h80);
		for (int k = 0; k < 3; k++) begin
			m = k[1:0];
			st = (m == 2'b01) ? 22'h1 : (m == 2'b10) ? 22'h3fffff : 22'h0;
			slow <= k[0];
			wr(`OFS_ADDR_CTRL, {m, 1'b0, m, m, 1'b0});
			wr(`OFS_SSA_L, 8'h10);
			wr(`OFS_SSA_H, 8'h01);
			wr(`OFS_SSZ_L, 8'h02);
			wr(`OFS_DSA_H, 8'h02);
			wr(`OFS_DSZ_L, 8'h02);
			wr(`OFS_CTRL_MAIN, 8'ha0);
			wait_idle;
			chk(v, 32'h80);
			chk({10'h0, raddr}, {10'h0, 22'h110 + st});
			chk({10'h0, waddr}, {10'h0, 22'h200 + st});
			chk({30'h0, rreg}, {30'h0, m});
			chk({24'h0, wbyte}, {24'h0, (8'h10 + st[7:0]) ^ 8'h5a});
			rc(`OFS_STAGE, {24'h0, (8'h10 + st[7:0]) ^ 8'h5a});
			rc(`OFS_SOURCE_POINTER_L, 32'h10);
			rc(`OFS_SOURCE_REMAINING_L, 32'h02);
		end
	endtask
	task automatic t_trig;
		integer n0;
		wr(`OFS_CTRL_MAIN, 8'h00);
		n0 = nwr;
		pulse;
		chk(nwr, n0);
		wr(`OFS_CTRL_MAIN, 8'h80);
		wr(`OFS_SSZ_L, 8'h01);
		wr(`OFS_DSZ_L, 8'h01);
		wr(`OFS_ADDR_CTRL, 8'h01);
		pulse;
		chk(nwr, n0);
		wr(`OFS_CTRL_MAIN, 8'hc0);
		pulse;
		wait_idle;
		chk(nwr, n0 + 1);
		chk(v, 32'h80);
	endtask
	task automatic t_abort;
		integer n0;
		wr(`OFS_CTRL_MAIN, 8'h00);
		wr(`OFS_CTRL_MAIN, 8'h80);
		wr(`OFS_SSZ_L, 8'h08);
		wr(`OFS_DSZ_L, 8'h08);
		wr(`OFS_ADDR_CTRL, 8'h42);
		slow <= 1'b1;
		n0 = nwr;
		wr(`OFS_CTRL_MAIN, 8'ha4);
		while (nwr == n0) @(posedge aclk);
		abort_trigger <= 1'b1;
		@(posedge aclk);
		abort_trigger <= 1'b0;
		wait_idle;
		chk(v & 32'hfe, 32'h80);
		chk(nwr - n0 < 8, 1);
		rc(`OFS_SOURCE_REMAINING_L, 32'h07);
		wr(`OFS_CTRL_MAIN, 8'ha0);
		wait_idle;
		chk(nwr - n0, 8);
		chk({10'h0, waddr}, 32'h7);
	endtask
	task report_and_stop;
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			errors = errors + 1;
			report_and_stop;
		end
	end
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_move;
		t_trig;
		t_abort;
		report_and_stop;
	end
endmodule

// ===== dma_defs.vh
`ifndef DMA_DEFS_VH
`define DMA_DEFS_VH
// Register byte offsets
`define OFS_CTRL_MAIN 8'h00
`define OFS_ADDR_CTRL 8'h04
`define OFS_STAGE 8'h08
`define OFS_SSA_L 8'h0c
`define OFS_SSA_H 8'h10
`define OFS_SSA_U 8'h14
`define OFS_SOURCE_POINTER_L 8'h18
`define OFS_SOURCE_POINTER_H 8'h1c
`define OFS_SOURCE_POINTER_U 8'h20
`define OFS_SSZ_L 8'h24
`define OFS_SSZ_H 8'h28
`define OFS_SOURCE_REMAINING_L 8'h2c
`define OFS_SOURCE_REMAINING_H 8'h30
`define OFS_DSA_L 8'h34
`define OFS_DSA_H 8'h38
`define OFS_DEST_POINTER_L 8'h3c
`define OFS_DEST_POINTER_H 8'h40
`define OFS_DSZ_L 8'h44
`define OFS_DSZ_H 8'h48
`define OFS_DEST_REMAINING_L 8'h4c
`define OFS_DEST_REMAINING_H 8'h50
// Main control bit positions
`define BIT_EN 7
`define BIT_SIRQ 6
`define BIT_GO 5
`define BIT_AIRQ 2
`define BIT_PEND 0
// Addressing control fields
`define DEST_ADDR_MODE_HI 7
`define DEST_ADDR_MODE_LO 6
`define BIT_DEST_RELOAD_STOP 5
`define SMR_HI 4
`define SMR_LO 3
`define SOURCE_ADDR_MODE_HI 2
`define SOURCE_ADDR_MODE_LO 1
`define BIT_SOURCE_RELOAD_STOP 0
// Address modes
`define MODE_HOLD 2'b00
`define MODE_INC 2'b01
`define MODE_DEC 2'b10
// Reset value of all fields
`define REG_RESET 8'h00
// Bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ===== mem_model.sv
`timescale 1ns/10ps
module mem_model (
	input wire aclk,
	input wire aresetn,
	input wire mem_req,
	input wire mem_write,
	input wire [1:0] mem_region,
	input wire [21:0] mem_addr,
	input wire [7:0] mem_wdata,
	input wire slow,
	output reg mem_grant,
	output reg [7:0] mem_rdata,
	output reg [21:0] waddr,
	output reg [7:0] wbyte,
	output reg [21:0] raddr,
	output reg [1:0] rreg,
	output integer nwr
);
	reg wt;
	// Idle read data toggles every cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			mem_grant <= 1'b0;
			mem_rdata <= 8'h00;
			wt <= 1'b0;
			nwr <= 0;
		end else begin
			mem_grant <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_grant) begin
				wt <= ~wt;
				if (!slow || wt) begin
					mem_grant <= 1'b1;
					if (mem_write) begin
						waddr <= mem_addr;
						wbyte <= mem_wdata;
						nwr <= nwr + 1;
					end else begin
						mem_rdata <= mem_addr[7:0] ^ 8'h5a;
						raddr <= mem_addr;
						rreg <= mem_region;
					end
				end
			end
		end
	end
endmodule
